//--- hw/fus_fifo.sv
// Purpose: small synchronous fifo in the write data path
// Assumes: single clock, push and pop by valid and ready
// Notes: full and empty are exact; one entry is free when ready is high
`timescale 1ns/100ps
`default_nettype none
module fus_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fus_fifo_s;
	fus_fifo_s st_q, st_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic push, pop;
	assign in_ready_out = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (st_q.cnt != '0);
	assign out_data_out = mem_q[st_q.rd];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.wr = st_q.wr + 1'b1;
		end
		if (pop) begin
			st_d.rd = st_q.rd + 1'b1;
		end
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_q[st_q.wr] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

//--- hw/fus_pkg.sv
// Purpose: shared constants for the flash update serial sender
// Assumes: 100 MHz system clock
// Notes: link is 8 data bits, no parity, one stop bit
package fus_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_BPS = 31_250;
	// one bit time in clock cycles, rounded down
	localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
	localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
	localparam logic [7:0] BEGIN_UPDATE_CMD = 8'h10;
	localparam logic [7:0] ERASE_CMD = 8'h11;
	localparam logic [7:0] WRITE_CMD = 8'h12;
	localparam logic [7:0] GO_AHEAD_STATUS_CODE = 8'h55;
	localparam logic [7:0] PAD_BYTE = 8'hff;
	localparam int unsigned BLOCK_BYTES = 128;
	localparam int unsigned SIZE_BYTES = 4;
	localparam int unsigned FIFO_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 4;
	// rotation step of the normal end indication: 250 ms
	localparam int unsigned ROTATE_MS = 250;
	localparam int unsigned ROTATE_CYCLES = ROTATE_MS * (CLK_HZ / 1000);
	localparam logic [3:0] IND_READY = 4'hf;
	localparam logic [3:0] IND_RUN = 4'h0;
	localparam logic [3:0] IND_END_FIRST = 4'h1;
	localparam logic [7:0] ERR_OVERRUN = 8'h01;
	localparam logic [7:0] ERR_FRAMING = 8'h02;
	localparam logic [3:0] IND_OVERRUN = 4'h8;
	localparam logic [3:0] IND_FRAMING = 4'h9;
	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_WAIT, ST_CMD, ST_SIZE, ST_DATA, ST_PAD, ST_DONE, ST_ERROR
	} fus_state_e;
	typedef enum logic [1:0] {
		TX_IDLE, TX_SHIFT
	} fus_tx_e;
	typedef enum logic [1:0] {
		RX_IDLE, RX_SHIFT, RX_STOP
	} fus_rx_e;
endpackage

//--- hw/fus_sender.sv
// Purpose: master side sender of a flash update over an asynchronous serial link
// Assumes: slave ready and start switch are synchronous levels; write data arrives over valid/ready
// Notes: each command byte, each size byte and each block of 128 bytes waits for the slave's go-ahead byte before the next one
`timescale 1ns/100ps
`default_nettype none
module fus_sender
	import fus_pkg::*;
(
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic slave_ready_in,
	input wire logic [31:0] write_size_in,
	input wire logic data_valid_in,
	output logic data_ready_out,
	input wire logic [7:0] data_in,
	output logic txd_out,
	input wire logic rxd_in,
	output logic [3:0] indicator_out,
	output logic [7:0] error_code_out,
	output logic busy_out,
	output logic rx_overrun_flag_out,
	output logic rx_framing_flag_out
);
	typedef struct packed {
		fus_state_e st;
		fus_tx_e tx_st;
		logic [12:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		fus_rx_e rx_st;
		logic [12:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_full;
		logic [7:0] rx_byte;
		logic rx_overrun_flag;
		logic rx_framing_flag;
		logic [31:0] remain;
		logic [31:0] write_size;
		logic [1:0] size_idx;
		logic [7:0] blk_cnt;
		logic [1:0] cmd_idx;
		logic [31:0] rot_cnt;
		logic [3:0] ind;
		logic [7:0] err;
		logic txd;
	} fus_sender_s;
	fus_sender_s s_q, s_d;
	logic f_valid, f_ready;
	logic [7:0] f_data;
	logic tx_free, go_ahead;
	function automatic logic [7:0] size_byte(input logic [31:0] sz, input logic [1:0] idx);
		size_byte = sz[8*idx +: 8];
	endfunction
	fus_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.in_valid_in(data_valid_in),
		.in_ready_out(data_ready_out),
		.in_data_in(data_in),
		.out_valid_out(f_valid),
		.out_ready_in(f_ready),
		.out_data_out(f_data)
	);
	assign tx_free = (s_q.tx_st == TX_IDLE);
	assign go_ahead = s_q.rx_full && (s_q.rx_byte == GO_AHEAD_STATUS_CODE);
	assign f_ready = (s_q.st == ST_DATA) && tx_free && (s_q.remain != '0);
	always_comb begin
		s_d = s_q;
		// 8n1 transmitter
		// each bit is put on the line at the start of its period, so the start bit follows the load at once
		if (s_q.tx_st == TX_SHIFT) begin
			if (s_q.tx_cnt == '0) begin
				if (s_q.tx_bit == 4'd10) begin
					s_d.tx_st = TX_IDLE;
					s_d.txd = 1'b1;
				end else begin
					s_d.txd = s_q.tx_sh[0];
					s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
					s_d.tx_bit = s_q.tx_bit + 4'd1;
				end
			end
			if (s_q.tx_cnt == 13'(BIT_CYCLES - 1)) begin
				s_d.tx_cnt = '0;
			end else begin
				s_d.tx_cnt = s_q.tx_cnt + 13'd1;
			end
		end
		case (s_q.rx_st)
			RX_IDLE: begin
				s_d.rx_cnt = '0;
				if (!rxd_in) begin
					s_d.rx_st = RX_SHIFT;
					s_d.rx_bit = '0;
					s_d.rx_cnt = 13'(BIT_CYCLES + HALF_BIT_CYCLES);
				end
			end
			RX_SHIFT: begin
				if (s_q.rx_cnt == 13'd1) begin
					s_d.rx_sh = {rxd_in, s_q.rx_sh[7:1]};
					s_d.rx_cnt = 13'(BIT_CYCLES);
					s_d.rx_bit = s_q.rx_bit + 3'd1;
					if (s_q.rx_bit == 3'd7) begin
						s_d.rx_st = RX_STOP;
					end
				end else begin
					s_d.rx_cnt = s_q.rx_cnt - 13'd1;
				end
			end
			RX_STOP: begin
				if (s_q.rx_cnt == 13'd1) begin
					s_d.rx_st = RX_IDLE;
					if (!rxd_in) begin
						s_d.rx_framing_flag = 1'b1;
					end else if (s_q.rx_full) begin
						s_d.rx_overrun_flag = 1'b1;
					end else begin
						s_d.rx_full = 1'b1;
						s_d.rx_byte = s_q.rx_sh;
					end
				end else begin
					s_d.rx_cnt = s_q.rx_cnt - 13'd1;
				end
			end
			default: s_d.rx_st = RX_IDLE;
		endcase
		case (s_q.st)
			ST_IDLE: begin
				s_d.ind = IND_RUN;
				if (slave_ready_in) begin
					s_d.ind = IND_READY;
					if (start_in) begin
						s_d.st = ST_CMD;
						s_d.cmd_idx = '0;
						s_d.write_size = write_size_in;
						s_d.rx_full = 1'b0;
					end
				end
			end
			ST_CMD: begin
				if (tx_free) begin
					s_d.st = ST_WAIT;
					s_d.tx_st = TX_SHIFT;
					s_d.tx_cnt = '0;
					s_d.tx_bit = '0;
					s_d.tx_sh = {1'b1, (s_q.cmd_idx == 2'd0) ? BEGIN_UPDATE_CMD : WRITE_CMD, 1'b0};
				end
			end
			ST_SIZE: begin
				if (tx_free) begin
					s_d.st = ST_WAIT;
					s_d.tx_st = TX_SHIFT;
					s_d.tx_cnt = '0;
					s_d.tx_bit = '0;
					// four size bytes low byte first
					s_d.tx_sh = {1'b1, size_byte(s_q.write_size, s_q.size_idx), 1'b0};
					s_d.size_idx = s_q.size_idx + 2'd1;
				end
			end
			ST_DATA, ST_PAD: begin
				if (tx_free && ((s_q.remain == '0) || f_valid)) begin
					s_d.tx_st = TX_SHIFT;
					s_d.tx_cnt = '0;
					s_d.tx_bit = '0;
					s_d.tx_sh = {1'b1, (s_q.remain == '0) ? PAD_BYTE : f_data, 1'b0};
					if (s_q.remain != '0) begin
						s_d.remain = s_q.remain - 32'd1;
					end
					s_d.blk_cnt = s_q.blk_cnt + 8'd1;
					if (s_q.blk_cnt == 8'(BLOCK_BYTES - 1)) begin
						s_d.st = ST_WAIT;
						s_d.blk_cnt = '0;
					end
				end
			end
			ST_WAIT: begin
				if (go_ahead && tx_free) begin
					s_d.rx_full = 1'b0;
					if (s_q.cmd_idx == 2'd0) begin
						s_d.cmd_idx = 2'd1;
						s_d.st = ST_CMD;
					end else if (s_q.cmd_idx == 2'd1) begin
						s_d.cmd_idx = 2'd2;
						s_d.size_idx = '0;
						s_d.st = ST_SIZE;
					end else if (s_q.cmd_idx == 2'd2 && s_q.size_idx != '0) begin
						s_d.st = ST_SIZE;
					end else if (s_q.cmd_idx == 2'd2) begin
						s_d.cmd_idx = 2'd3;
						s_d.remain = s_q.write_size;
						s_d.blk_cnt = '0;
						s_d.st = (s_q.write_size == '0) ? ST_DONE : ST_DATA;
					end else begin
						s_d.st = (s_q.remain == '0) ? ST_DONE : ST_DATA;
					end
					s_d.ind = IND_END_FIRST;
					s_d.rot_cnt = '0;
				end else if (s_q.rx_full) begin
					s_d.rx_full = 1'b0;
				end
			end
			ST_DONE: begin
				if (s_q.rot_cnt == ROTATE_CYCLES - 1) begin
					s_d.rot_cnt = '0;
					s_d.ind = {s_q.ind[2:0], s_q.ind[3]};
				end else begin
					s_d.rot_cnt = s_q.rot_cnt + 32'd1;
				end
			end
			ST_ERROR: begin
			end
			default: s_d.st = ST_IDLE;
		endcase
		// judged on the next state, so the first end pattern survives the step into done
		if (s_d.st != ST_DONE && s_d.st != ST_ERROR && s_d.st != ST_IDLE) begin
			s_d.ind = IND_RUN;
		end
		if (s_q.st != ST_ERROR && (s_q.rx_overrun_flag || s_q.rx_framing_flag)) begin
			s_d.st = ST_ERROR;
			s_d.err = s_q.rx_overrun_flag ? ERR_OVERRUN : ERR_FRAMING;
			s_d.ind = s_q.rx_overrun_flag ? IND_OVERRUN : IND_FRAMING;
		end
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
			s_q.txd <= 1'b1;
			s_q.st <= ST_IDLE;
			s_q.tx_st <= TX_IDLE;
			s_q.rx_st <= RX_IDLE;
		end else begin
			s_q <= s_d;
		end
	end
	assign txd_out = s_q.txd;
	assign indicator_out = s_q.ind;
	assign error_code_out = s_q.err;
	assign busy_out = (s_q.st != ST_IDLE) && (s_q.st != ST_DONE) && (s_q.st != ST_ERROR);
	assign rx_overrun_flag_out = s_q.rx_overrun_flag;
	assign rx_framing_flag_out = s_q.rx_framing_flag;
endmodule
`default_nettype wire

//--- tb/fus_sender_checker.sv
// Purpose: port checker for the flash update sender
// Assumes: sees only the sender's ports
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module fus_sender_checker
	import fus_pkg::*;
(
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic slave_ready_in,
	input wire logic [31:0] write_size_in,
	input wire logic data_valid_in,
	input wire logic data_ready_out,
	input wire logic [7:0] data_in,
	input wire logic txd_out,
	input wire logic rxd_in,
	input wire logic [3:0] indicator_out,
	input wire logic [7:0] error_code_out,
	input wire logic busy_out,
	input wire logic rx_overrun_flag_out,
	input wire logic rx_framing_flag_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	// low runs on the line must be whole bit times, a partial bit breaks the slave's sampling
	logic [31:0] low_q;
	logic [31:0] low_d;
	always_comb low_d = txd_out ? 32'h0 : low_q + 32'h1;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			low_q <= 32'h0;
		end else begin
			low_q <= low_d;
		end
	end
	a_start_bit_soon: assert property ($rose(busy_out) |-> ##[0:3] !txd_out)
		else $error("no start bit after start");
	a_low_run_whole: assert property ($rose(txd_out) |-> (low_q % BIT_CYCLES) == 0)
		else $error("low run not whole bit times");
	a_overrun_shown: assert property (error_code_out == ERR_OVERRUN |-> indicator_out == IND_OVERRUN)
		else $error("overrun indication wrong");
	a_framing_shown: assert property (error_code_out == ERR_FRAMING |-> indicator_out == IND_FRAMING)
		else $error("framing indication wrong");
	a_error_stays_put: assert property (error_code_out != 8'h00 |=> $stable(error_code_out))
		else $error("error code changed");
	a_framing_flag_held: assert property (rx_framing_flag_out |=> rx_framing_flag_out)
		else $error("framing flag dropped");
	a_overrun_flag_held: assert property (rx_overrun_flag_out |=> rx_overrun_flag_out)
		else $error("overrun flag dropped");
	a_framing_to_error: assert property ($rose(rx_framing_flag_out) && !rx_overrun_flag_out && busy_out
		&& error_code_out == 8'h00 |-> ##[0:2] error_code_out == ERR_FRAMING)
		else $error("framing error not handled");
	a_overrun_to_error: assert property ($rose(rx_overrun_flag_out) && busy_out && error_code_out == 8'h00
		|-> ##[0:2] error_code_out == ERR_OVERRUN)
		else $error("overrun not handled");
	c_started: cover property ($rose(busy_out));
	c_framing: cover property (error_code_out == ERR_FRAMING);
	c_long_low: cover property ($rose(txd_out) && low_q > BIT_CYCLES);
endmodule
bind fus_sender fus_sender_checker chk (.clock_in(clock_in), .rstn_in(rstn_in), .start_in(start_in),
	.slave_ready_in(slave_ready_in), .write_size_in(write_size_in), .data_valid_in(data_valid_in),
	.data_ready_out(data_ready_out), .data_in(data_in), .txd_out(txd_out), .rxd_in(rxd_in),
	.indicator_out(indicator_out), .error_code_out(error_code_out), .busy_out(busy_out),
	.rx_overrun_flag_out(rx_overrun_flag_out), .rx_framing_flag_out(rx_framing_flag_out));
`default_nettype wire

//--- tb/fus_slave_model.sv
// Purpose: behavioural slave on the serial link
// Assumes: 8 data bits, no parity, one stop bit
// Notes: a byte with a bad stop bit is not counted
`timescale 1ns/100ps
`default_nettype none
module fus_slave_model
	import fus_pkg::*;
(
	input wire logic clock_in,
	input wire logic txd_in,
	output logic rxd_out
);
	logic [7:0] got;
	logic [7:0] b;
	int unsigned got_count;
	initial begin
		rxd_out = 1'b1;
		got = 8'h00;
		got_count = 0;
		forever begin
			@(negedge txd_in);
			repeat (HALF_BIT_CYCLES) @(posedge clock_in);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clock_in);
				b[i] = txd_in;
			end
			repeat (BIT_CYCLES) @(posedge clock_in);
			if (txd_in === 1'b1) begin
				got = b;
				got_count++;
			end
		end
	end
	task automatic send_byte(input logic [7:0] v, input logic stop_ok);
		logic [9:0] f;
		f = {stop_ok, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock_in);
			#1 rxd_out = f[i];
			repeat (BIT_CYCLES - 1) @(posedge clock_in);
		end
		@(posedge clock_in);
		#1 rxd_out = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_flash_update_uart_master_sender.sv
// Purpose: self-checking bench for the flash update sender
// Assumes: slave model answers on the serial link
// Notes: full blocks take millions of cycles, so only the opening bytes are run
`timescale 1ns/100ps
`default_nettype none
module tb_flash_update_uart_master_sender;
	import fus_pkg::*;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic start_in = 1'b0;
	logic slave_ready_in = 1'b0;
	logic data_ready_out;
	logic txd_out;
	logic rxd_in;
	logic busy_out;
	logic ovr_flag;
	logic frm_flag;
	logic [3:0] indicator_out;
	logic [7:0] error_code_out;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 clock_in = ~clock_in;
	fus_sender dut (.clock_in(clock_in), .rstn_in(rstn_in), .start_in(start_in), .slave_ready_in(slave_ready_in),
		.write_size_in(32'h00002040), .data_valid_in(1'b0), .data_ready_out(data_ready_out), .data_in(8'h00),
		.txd_out(txd_out), .rxd_in(rxd_in), .indicator_out(indicator_out), .error_code_out(error_code_out),
		.busy_out(busy_out), .rx_overrun_flag_out(ovr_flag), .rx_framing_flag_out(frm_flag));
	fus_slave_model partner (.clock_in(clock_in), .txd_in(txd_out), .rxd_out(rxd_in));
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 600000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic do_reset();
		@(posedge clock_in);
		#1 rstn_in = 1'b0;
		repeat (16) @(posedge clock_in);
		#1 rstn_in = 1'b1;
	endtask
	task automatic pulse_start();
		@(posedge clock_in);
		#1 start_in = 1'b1;
		@(posedge clock_in);
		#1 start_in = 1'b0;
	endtask
	task automatic wait_byte(input logic [7:0] exp);
		int unsigned n;
		n = partner.got_count;
		for (int i = 0; i < 40000 && partner.got_count == n; i++) @(posedge clock_in);
		check("tx count", n + 1, partner.got_count);
		check("tx byte", exp, partner.got);
	endtask
	task automatic t_refused();
		pulse_start();
		repeat (20) @(posedge clock_in);
		check("busy", 1'b0, busy_out);
		check("txd", 1'b1, txd_out);
		check("fifo ready", 1'b1, data_ready_out);
		#1 slave_ready_in = 1'b1;
		repeat (3) @(posedge clock_in);
		check("ready indicator", IND_READY, indicator_out);
	endtask
	task automatic t_sequence();
		int unsigned c0;
		pulse_start();
		wait_byte(BEGIN_UPDATE_CMD);
		c0 = partner.got_count;
		partner.send_byte(8'haa, 1'b1);
		partner.send_byte(GO_AHEAD_STATUS_CODE, 1'b1);
		wait_byte(WRITE_CMD);
		check("bytes after go-ahead", c0 + 1, partner.got_count);
		partner.send_byte(GO_AHEAD_STATUS_CODE, 1'b1);
		wait_byte(8'h40);
	endtask
	task automatic t_framing();
		do_reset();
		pulse_start();
		wait_byte(BEGIN_UPDATE_CMD);
		partner.send_byte(GO_AHEAD_STATUS_CODE, 1'b0);
		repeat (BIT_CYCLES) @(posedge clock_in);
		check("framing flag", 1'b1, frm_flag);
		check("overrun flag", 1'b0, ovr_flag);
		check("error code", ERR_FRAMING, error_code_out);
		check("error indicator", IND_FRAMING, indicator_out);
		check("line idle", 1'b1, txd_out);
	endtask
	initial begin
		do_reset();
		t_refused();
		t_sequence();
		t_framing();
		print_verdict();
	end
endmodule
`default_nettype wire
